// ---- verif/e1_far_end.sv ----
// Far-end E1 terminal model driving the received overhead bytes
`timescale 1ns/100ps
`default_nettype none

module e1_far_end
  import e1_align_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Received overhead
  output var ebit_capture_t ebit_o,
  output var word_capture_t fas_o,
  output var word_capture_t nfas_o,
  output var word_capture_t mfas_o
);
  // Idle until the first frame arrives
  initial begin
    ebit_o = '0;
    fas_o  = '0;
    nfas_o = '0;
    mfas_o = '0;
  end

  // One byte per valid; data inverted afterwards so a stale byte never matches
  task automatic send(input int sel, input logic [7:0] d);
    @(posedge clk);
    case (sel)
      0: fas_o <= '{1'b1, d};
      1: nfas_o <= '{1'b1, d};
      default: mfas_o <= '{1'b1, d};
    endcase
    @(posedge clk);
    fas_o  <= '{1'b0, ~fas_o.data};
    nfas_o <= '{1'b0, ~nfas_o.data};
    mfas_o <= '{1'b0, ~mfas_o.data};
  endtask : send

  // E bits of one multiframe, sent as a pair
  task automatic send_e(input logic a, input logic b);
    @(posedge clk);
    ebit_o <= '{1'b1, a, b};
    @(posedge clk);
    ebit_o <= '{1'b0, ~a, ~b};
  endtask : send_e
endmodule : e1_far_end

`default_nettype wire

// ---- verif/e1_receive_alignment_status_test.sv ----
// Self-checking bench for the E1 receive alignment status block
`timescale 1ns/100ps
`default_nettype none

module e1_receive_alignment_status_test
  import e1_align_pkg::*;
;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  align_state_t  align_in = 4'b1110;
  ebit_capture_t ebit_w;
  word_capture_t fas_w, nfas_w, mfas_w;
  logic [7:0]    reg_addr = 8'h00;
  logic [7:0]    wr_data = 8'h00;
  logic          wr_strobe = 1'b0;
  logic          rd_strobe = 1'b0;
  logic [7:0]    rd_data;
  int            fail_count = 0;
  int            samples_checked = 0;
  logic [7:0]    d;
  int            g;

  // 50 MHz clock
  always #10 clk = ~clk;

  e1_receive_alignment_status #(.TICK_CYCLES(10)) dut_u (
    .clk(clk), .reset_n(reset_n), .align_in(align_in), .ebit_in(ebit_w),
    .fas_in(fas_w), .nfas_in(nfas_w), .mfas_in(mfas_w), .reg_addr(reg_addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data));

  e1_far_end far_u (
    .clk(clk), .ebit_o(ebit_w), .fas_o(fas_w), .nfas_o(nfas_w), .mfas_o(mfas_w));

  // ------------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------------
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check_num(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : check_num

  // Data stands only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    reg_addr  <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 q = rd_data;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    wr_data   <= v;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask : wr

  // Back-to-back reads of the timer word; cycles between two changes of bit b
  task automatic gap(input int b, output int n_gap, output logic [7:0] w);
    logic [7:0] prev;
    int         t0, n;
    t0 = -1;
    n_gap = -1;
    n = 0;
    @(posedge clk);
    reg_addr  <= 8'h12;
    rd_strobe <= 1'b1;
    @(posedge clk);
    #1 prev = rd_data;
    while (n_gap < 0 && n < 12000) begin
      @(posedge clk);
      #1 n++;
      if (rd_data[b] !== prev[b]) begin
        if (t0 < 0) t0 = n;
        else n_gap = n - t0;
      end
      prev = rd_data;
    end
    w = prev;
    @(posedge clk);
    rd_strobe <= 1'b0;
    if (n_gap < 0) begin
      fail_count++;
      end_sim();
    end
  endtask : gap

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic reset_check();
    rd(8'h10, d);
    check8(d, 8'hE2);
    for (int a = 16; a < 21; a++) wr(a[7:0], 8'hFF);
    rd(8'h10, d);
    check8(d, 8'hE2);
    rd(8'h11, d);
    check8(d, 8'h00);
    rd(8'h15, d);
    check8(d, 8'h00);
  endtask : reset_check

  task automatic timer_check();
    gap(7, g, d);
    check_num(g, 5000);
    check8({4'h0, d[7:4]}, 8'h04);
    gap(5, g, d);
    check_num(g, 80);
    check8({4'h0, d[7:4]}, 8'h00);
  endtask : timer_check

  task automatic capture_check();
    logic [7:0] pat [4] = '{8'h9B, 8'hE5, 8'h0D, 8'h72};
    for (int i = 0; i < 4; i++) begin
      for (int s = 0; s < 3; s++) begin
        far_u.send(s, pat[(i + s) % 4]);
        rd(8'h11 + s[7:0] + (s > 0 ? 8'h01 : 8'h00), d);
        check8(d, pat[(i + s) % 4]);
      end
    end
    far_u.send_e(1'b1, 1'b0);
    rd(8'h10, d);
    check8(d, 8'hF2);
    far_u.send_e(1'b0, 1'b1);
    rd(8'h10, d);
    check8(d, 8'hEA);
  endtask : capture_check

  task automatic align_check();
    @(posedge clk) align_in <= 4'b0010;
    repeat (50) @(posedge clk);
    rd(8'h10, d);
    check8(d, 8'h2A);
    repeat (70) @(posedge clk);
    rd(8'h10, d);
    check8(d, 8'h2C);
    gap(1, g, d);
    check_num(g, 20);
    gap(2, g, d);
    check_num(g, 80);
    @(posedge clk) align_in <= 4'b0000;
    repeat (3) @(posedge clk);
    rd(8'h10, d);
    check8(d, 8'h09);
    @(posedge clk) align_in <= 4'b0100;
    repeat (3) @(posedge clk);
    rd(8'h10, d);
    check8(d, 8'h49);
    @(posedge clk) align_in <= 4'b0001;
    repeat (3) @(posedge clk);
    rd(8'h12, d);
    check8(d & 8'h03, 8'h02);
    @(posedge clk) align_in <= 4'b0000;
    repeat (3) @(posedge clk);
    rd(8'h12, d);
    check8(d & 8'h03, 8'h00);
    @(posedge clk) align_in <= 4'b0010;
    gap(3, g, d);
    check_num(g, 4000);
    rd(8'h10, d);
    check8(d, 8'h2C);
    @(posedge clk) align_in <= 4'b1010;
    repeat (3) @(posedge clk);
    rd(8'h10, d);
    check8(d & 8'hC2, 8'h82);
  endtask : align_check

  // Main sequence; a bounded wait that runs out ends the run early
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    reset_check();
    timer_check();
    capture_check();
    align_check();
    end_sim();
  end
endmodule : e1_receive_alignment_status_test

`default_nettype wire

// ---- verilog/e1_align_params.svh ----
// Constants of the E1 receive alignment status block
`ifndef E1_ALIGN_PARAMS_SVH
`define E1_ALIGN_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define FRAME_SYNC_STATUS_OFF        8'h10
`define RECEIVED_FAS_BITS_OFF        8'h11
`define ALIGNMENT_TIMER_STATUS_OFF   8'h12
`define RECEIVED_NFAS_BITS_OFF       8'h13
`define RECEIVED_MULTIFRAME_BITS_OFF 8'h14
`define UNMAPPED_READ_VALUE          8'h00

// ----------------------------------------------------------------------
// Field positions, synchronization status word
// ----------------------------------------------------------------------
`define SYNC_FRAME_LOSS_BIT     7
`define SYNC_TS16_LOSS_BIT      6
`define SYNC_CRC_LOSS_BIT       5
`define SYNC_EBIT_FIRST_BIT     4
`define SYNC_EBIT_SECOND_BIT    3
`define SYNC_CRC_TIMEOUT_BIT    2
`define SYNC_PERSIST_BIT        1
`define SYNC_INTERWORK_BIT      0

// ----------------------------------------------------------------------
// Field positions, timer status word
// ----------------------------------------------------------------------
`define TMR_HALF_SECOND_BIT     7
`define TMR_ONE_SECOND_BIT      6
`define TMR_CRC_INTERVAL_BIT    5
`define TMR_EBIT_INTERVAL_BIT   4
`define TMR_LONG_ALIGN_BIT      3
`define TMR_SHORT_ALIGN_BIT     2
`define TMR_CRC_ALIGN_CLK_BIT   1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LOSS_RESET_VALUE        1'b1
`define CAPTURE_RESET_VALUE     8'h00
`define INTERWORK_RESET_VALUE   1'b0

// ----------------------------------------------------------------------
// Timing: base tick of one millisecond, all timers count ticks
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS           20
`define MS_TICK_NS              1000000
`define MS_TICK_CYCLES          (`MS_TICK_NS / `CLK_PERIOD_NS)
`define PERSIST_MS              8
`define CRC_SEARCH_MS           8
`define LONG_ALIGN_MS           400
`define CRC_ALIGN_CLK_MS        2
`define HALF_SECOND_MS          500
`define ONE_SECOND_MS           1000
`define ACCUM_FLAG_HIGH_MS      8

`endif

// ---- verilog/e1_align_pkg.sv ----
// Types shared by the E1 receive alignment status block
package e1_align_pkg;

  // Alignment levels from the framer core
  typedef struct packed {
    logic frame_loss;
    logic ts16_multiframe_loss;
    logic crc_multiframe_loss;
    logic crc_mf_phase;
  } align_state_t;

  // Received E bits, one strobe per multiframe
  typedef struct packed {
    logic valid;
    logic rx_ebit_first;
    logic rx_ebit_second;
  } ebit_capture_t;

  // Received overhead byte; data[7] is the first bit on the line
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } word_capture_t;

endpackage : e1_align_pkg

// ---- verilog/e1_receive_alignment_status.sv ----
// E1 receive alignment and timer status words with register read port
//
// Summary of operation
// - Bit 7 shows basic frame alignment loss
// - Bit 6 shows time slot 16 multiframe loss
// - Bit 5 shows CRC-4 multiframe alignment loss
// - Bits 4 and 3 hold received E bits
// - Reframe flag after 8 ms without CRC-4 sync
// - Persistence flag stays 8 ms after realignment
// - Bit 0 shows CRC-4 interworking with far end
// - Capture received frame alignment word
// - Half-period timer bit toggles every 0.5 s
// - One-second toggle bit, in step with half
// - CRC interval bit falls each second, 8 ms high
// - E-bit interval bit falls each second, 8 ms high
// - Long timer bit inverts on 400 ms expiry
// - Short timer bit inverts on 8 ms expiry
// - Alignment clock: 2 ms toggle, else follows multiframe
// - Capture non-frame alignment word and national bits
// - Bit 5 of that word is remote alarm
// - Multiframe register bits 7-4 hold TS16 pattern
// - Multiframe register bit 2 is remote loss
// - Spare bits go to bits 3, 1, 0
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

`include "e1_align_params.svh"

module e1_receive_alignment_status
  import e1_align_pkg::*;
#(
  parameter int TICK_CYCLES = `MS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Alignment levels from the framer core
  input  wire align_state_t  align_in,
  // Received overhead from the framer core
  input  wire ebit_capture_t ebit_in,
  input  wire word_capture_t fas_in,
  input  wire word_capture_t nfas_in,
  input  wire word_capture_t mfas_in,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic          wr_strobe,
  input  wire logic          rd_strobe,
  output logic      [7:0]    rd_data
);

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  localparam logic [9:0] HALF_LAST   = 10'(`HALF_SECOND_MS - 1);
  localparam logic [9:0] SECOND_LAST = 10'(`ONE_SECOND_MS - 1);
  localparam logic [9:0] FLAG_START  = 10'(`ONE_SECOND_MS - `ACCUM_FLAG_HIGH_MS);

  // ----------------------------------------------------------------------
  // Registered alignment levels
  // ----------------------------------------------------------------------
  logic frame_loss_q;
  logic ts16_multiframe_loss_q;
  logic crc_multiframe_loss_q;
  logic crc_mf_phase_q;

  // Same-clock inputs, one stage for a clean status timebase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_loss_q           <= `LOSS_RESET_VALUE;
      ts16_multiframe_loss_q <= `LOSS_RESET_VALUE;
      crc_multiframe_loss_q  <= `LOSS_RESET_VALUE;
      crc_mf_phase_q         <= 1'b0;
    end else begin
      frame_loss_q           <= align_in.frame_loss;
      ts16_multiframe_loss_q <= align_in.ts16_multiframe_loss;
      crc_multiframe_loss_q  <= align_in.crc_multiframe_loss;
      crc_mf_phase_q         <= align_in.crc_mf_phase;
    end
  end

  // ----------------------------------------------------------------------
  // Captured overhead bits
  // ----------------------------------------------------------------------
  logic [7:0] fas_q;
  logic [7:0] nfas_q;
  logic [7:0] mfas_q;
  logic       rx_ebit_first_q;
  logic       rx_ebit_second_q;

  // Each word is replaced whole when the core marks it received
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fas_q            <= `CAPTURE_RESET_VALUE;
      nfas_q           <= `CAPTURE_RESET_VALUE;
      mfas_q           <= `CAPTURE_RESET_VALUE;
      rx_ebit_first_q  <= 1'b0;
      rx_ebit_second_q <= 1'b0;
    end else begin
      if (fas_in.valid) fas_q <= fas_in.data;
      if (nfas_in.valid) nfas_q <= nfas_in.data;
      if (mfas_in.valid) mfas_q <= mfas_in.data;
      if (ebit_in.valid) begin
        rx_ebit_first_q  <= ebit_in.rx_ebit_first;
        rx_ebit_second_q <= ebit_in.rx_ebit_second;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------------
  logic ms_tick;

  tick_divider #(.DIVIDE(TICK_CYCLES)) u_ms_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick)
  );

  // ----------------------------------------------------------------------
  // Alignment timers
  // ----------------------------------------------------------------------
  logic persist_expire;
  logic short_expire;
  logic long_expire;
  logic crc_align_clock_expire;
  logic frame_loss_persist_q;

  // Search timers run only while frame aligned and CRC-4 sync absent
  wire crc_search   = ~frame_loss_q & crc_multiframe_loss_q;
  wire persist_run  = frame_loss_persist_q & ~frame_loss_q;

  interval_timer #(.LIMIT(`PERSIST_MS)) u_persist_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick),
    .run     (persist_run),
    .expire  (persist_expire)
  );

  interval_timer #(.LIMIT(`CRC_SEARCH_MS)) u_short_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick),
    .run     (crc_search),
    .expire  (short_expire)
  );

  interval_timer #(.LIMIT(`LONG_ALIGN_MS)) u_long_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick),
    .run     (crc_search),
    .expire  (long_expire)
  );

  interval_timer #(.LIMIT(`CRC_ALIGN_CLK_MS)) u_crc_align_clock_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (ms_tick),
    .run     (crc_multiframe_loss_q),
    .expire  (crc_align_clock_expire)
  );

  // ----------------------------------------------------------------------
  // Alignment flags
  // ----------------------------------------------------------------------
  logic crc_align_timeout_q;
  logic crc_interwork_state_q;
  logic long_align_timer_toggle_q;
  logic short_align_timer_toggle_q;
  logic crc_align_clock_toggle_q;

  // Loss raises the flag at once; only the timer after realign drops it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_loss_persist_q <= `LOSS_RESET_VALUE;
    end else if (frame_loss_q) begin
      frame_loss_persist_q <= 1'b1;
    end else if (persist_expire) begin
      frame_loss_persist_q <= 1'b0;
    end
  end

  // Timeout and interworking follow the CRC-4 search outcome
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_align_timeout_q   <= 1'b0;
      crc_interwork_state_q <= `INTERWORK_RESET_VALUE;
    end else begin
      if (!crc_multiframe_loss_q) begin
        crc_align_timeout_q <= 1'b0;
      end else if (short_expire) begin
        crc_align_timeout_q <= 1'b1;
      end
      if (!crc_multiframe_loss_q) begin
        crc_interwork_state_q <= 1'b1;
      end else if (long_expire) begin
        crc_interwork_state_q <= 1'b0;
      end
    end
  end

  // Expiry toggles, visible to software as change of state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      long_align_timer_toggle_q  <= 1'b0;
      short_align_timer_toggle_q <= 1'b0;
      crc_align_clock_toggle_q              <= 1'b0;
    end else begin
      if (long_expire) long_align_timer_toggle_q <= ~long_align_timer_toggle_q;
      if (short_expire) short_align_timer_toggle_q <= ~short_align_timer_toggle_q;
      if (crc_align_clock_expire) crc_align_clock_toggle_q <= ~crc_align_clock_toggle_q;
    end
  end

  // Free toggle while CRC-4 multiframe sync is lost, else the received multiframe phase
  wire crc_align_clock = crc_multiframe_loss_q ? crc_align_clock_toggle_q : crc_mf_phase_q;

  // ----------------------------------------------------------------------
  // One-second accumulation timebase
  // ----------------------------------------------------------------------
  logic [9:0] second_ms_q;
  logic       half_second_toggle_q;
  logic       one_second_toggle_q;

  // Both toggles share one counter, so they can never drift apart
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      second_ms_q          <= '0;
      half_second_toggle_q <= 1'b0;
      one_second_toggle_q  <= 1'b0;
    end else if (ms_tick) begin
      second_ms_q <= (second_ms_q == SECOND_LAST) ? '0 : second_ms_q + 10'd1;
      if (second_ms_q == HALF_LAST || second_ms_q == SECOND_LAST) begin
        half_second_toggle_q <= ~half_second_toggle_q;
      end
      if (second_ms_q == SECOND_LAST) begin
        one_second_toggle_q <= ~one_second_toggle_q;
      end
    end
  end

  // High over the last 8 ms of each second, falling as the interval opens
  wire crc_interval_flag   = (second_ms_q >= FLAG_START);
  wire e_bit_interval_flag = (second_ms_q >= FLAG_START);

  // ----------------------------------------------------------------------
  // Status words
  // ----------------------------------------------------------------------
  logic [7:0] sync_word;
  logic [7:0] timer_word;

  // Assembled by field position; unused bit reads zero
  always_comb begin
    sync_word                          = 8'h00;
    sync_word[`SYNC_FRAME_LOSS_BIT]    = frame_loss_q;
    sync_word[`SYNC_TS16_LOSS_BIT]     = ts16_multiframe_loss_q;
    sync_word[`SYNC_CRC_LOSS_BIT]      = crc_multiframe_loss_q;
    sync_word[`SYNC_EBIT_FIRST_BIT]    = rx_ebit_first_q;
    sync_word[`SYNC_EBIT_SECOND_BIT]   = rx_ebit_second_q;
    sync_word[`SYNC_CRC_TIMEOUT_BIT]   = crc_align_timeout_q;
    sync_word[`SYNC_PERSIST_BIT]       = frame_loss_persist_q;
    sync_word[`SYNC_INTERWORK_BIT]     = crc_interwork_state_q;
    timer_word                         = 8'h00;
    timer_word[`TMR_HALF_SECOND_BIT]   = half_second_toggle_q;
    timer_word[`TMR_ONE_SECOND_BIT]    = one_second_toggle_q;
    timer_word[`TMR_CRC_INTERVAL_BIT]  = crc_interval_flag;
    timer_word[`TMR_EBIT_INTERVAL_BIT] = e_bit_interval_flag;
    timer_word[`TMR_LONG_ALIGN_BIT]    = long_align_timer_toggle_q;
    timer_word[`TMR_SHORT_ALIGN_BIT]   = short_align_timer_toggle_q;
    timer_word[`TMR_CRC_ALIGN_CLK_BIT] = crc_align_clock;
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [7:0] rd_data_q;
  wire        hit_sync  = (reg_addr == `FRAME_SYNC_STATUS_OFF);
  wire        hit_fas   = (reg_addr == `RECEIVED_FAS_BITS_OFF);
  wire        hit_timer = (reg_addr == `ALIGNMENT_TIMER_STATUS_OFF);
  wire        hit_nfas  = (reg_addr == `RECEIVED_NFAS_BITS_OFF);
  wire        hit_mfas  = (reg_addr == `RECEIVED_MULTIFRAME_BITS_OFF);

  // Writes are not decoded at all, so nothing can disturb state
  wire [7:0] read_mux = hit_sync  ? sync_word  :
                        hit_fas   ? fas_q      :
                        hit_timer ? timer_word :
                        hit_nfas  ? nfas_q     :
                        hit_mfas  ? mfas_q     : `UNMAPPED_READ_VALUE;

  // Data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_strobe ? read_mux : 8'h00;
    end
  end

  assign rd_data = rd_data_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_frame_loss_read;
    rd_strobe && hit_sync |=> rd_data[7] == $past(align_in.frame_loss, 2);
  endproperty
  a_frame_loss_read: assert property (p_frame_loss_read)
    else $error("sync word bit 7 does not follow frame loss");
  property p_crc_loss_read;
    rd_strobe && hit_sync |=> rd_data[5] == $past(align_in.crc_multiframe_loss, 2);
  endproperty
  a_crc_loss_read: assert property (p_crc_loss_read)
    else $error("sync word bit 5 does not follow CRC-4 loss");
  property p_timeout_clears;
    !crc_multiframe_loss_q |=> !crc_align_timeout_q;
  endproperty
  a_timeout_clears: assert property (p_timeout_clears)
    else $error("reframe flag stays set after CRC-4 sync");
  property p_persist_hold;
    frame_loss_q ##1 !frame_loss_q |-> frame_loss_persist_q [*2];
  endproperty
  a_persist_hold: assert property (p_persist_hold)
    else $error("persistence flag dropped right after realignment");
  // Capture, one idle cycle, then a read of the word
  property p_fas_capture;
    fas_in.valid ##1 !fas_in.valid ##1 rd_strobe && hit_fas |=> rd_data == $past(fas_in.data, 3);
  endproperty
  a_fas_capture: assert property (p_fas_capture)
    else $error("frame alignment word not captured");
  property p_second_step;
    ms_tick && second_ms_q == SECOND_LAST |=>
      $changed(one_second_toggle_q) && $changed(half_second_toggle_q);
  endproperty
  a_second_step: assert property (p_second_step)
    else $error("second toggles out of step");
  property p_interval_fall;
    ms_tick && second_ms_q == SECOND_LAST |=> $fell(crc_interval_flag) && !e_bit_interval_flag;
  endproperty
  a_interval_fall: assert property (p_interval_fall)
    else $error("interval flag did not fall at second start");
  property p_long_toggle;
    long_expire |=> long_align_timer_toggle_q != $past(long_align_timer_toggle_q);
  endproperty
  a_long_toggle: assert property (p_long_toggle)
    else $error("long timer bit missed an expiry");
  property p_short_toggle;
    short_expire |=> $changed(short_align_timer_toggle_q) && crc_align_timeout_q;
  endproperty
  a_short_toggle: assert property (p_short_toggle)
    else $error("short timer bit or reframe flag missed an expiry");
  property p_write_silent;
    wr_strobe && !rd_strobe |=> rd_data == 8'h00;
  endproperty
  a_write_silent: assert property (p_write_silent)
    else $error("write produced read data");

endmodule : e1_receive_alignment_status

`default_nettype wire

// ---- verilog/interval_timer.sv ----
// Restartable millisecond interval timer with expiry pulse
`timescale 1ns/100ps
`default_nettype none

module interval_timer #(
  parameter int LIMIT = 8
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Control
  input  wire logic tick,
  input  wire logic run,
  // Expiry pulse, one cycle
  output logic      expire
);

  localparam int W = $clog2(LIMIT + 1);

  logic [W-1:0] count_q;
  wire          last = (count_q == W'(LIMIT - 1));

  // Expires on the tick that completes the interval, then restarts
  assign expire = run & tick & last;

  // Held at zero while stopped, so each run measures a full interval
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      count_q <= '0;
    end else if (tick) begin
      count_q <= last ? '0 : count_q + W'(1);
    end
  end

endmodule : interval_timer

`default_nettype wire

// ---- verilog/tick_divider.sv ----
// Clock divider that emits a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
  parameter int DIVIDE = 50000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Enable pulse
  output logic      tick
);

  localparam int W = $clog2(DIVIDE);

  logic [W-1:0] count_q;
  logic         tick_q;
  wire          wrap = (count_q == W'(DIVIDE - 1));

  // Free running count, pulse on wrap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      count_q <= wrap ? '0 : count_q + W'(1);
      tick_q  <= wrap;
    end
  end

  assign tick = tick_q;

endmodule : tick_divider

`default_nettype wire
